// ---- common/elp_params.svh ----
`ifndef ELP_PARAMS_SVH
`define ELP_PARAMS_SVH
`define ELP_AW          4
`define ELP_DW          8
`define ELP_NIRQ        8
`define ELP_IDXW        3
`define ELP_ADDR_BSR    4'h0
`define ELP_ADDR_BFCR   4'h1
`define ELP_ADDR_OPT    4'h2
`define ELP_ADDR_IEN    4'h3
`define ELP_ADDR_STAT   4'h4
`define ELP_BIT_BELP    1
`define ELP_BIT_BREAK_FLAG_CLEAR_ENABLE    7
`define ELP_BIT_WDD     0
`define ELP_BIT_SSR     7
`define ELP_OPT_RST     8'h00
`define ELP_IEN_RST     8'h00
`define ELP_CNTW        12
`define ELP_REC_LONG    12'hFFF
`define ELP_REC_SHORT   12'h01F
`define ELP_DIVW        2
`define ELP_DIV_LAST    2'h3
`define ELP_VECW        4
`define ELP_VEC_RESET   4'hF
`define ELP_VEC_SWI     4'hE
`define ELP_VEC_IRQ0    4'hD
`endif

// ---- common/elp_pkg.sv ----
package elp_pkg;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_WAIT  = 3'b001,
        ST_STOP  = 3'b010,
        ST_SREC  = 3'b011,
        ST_ENTRY = 3'b100
    } elp_state_t;

    // core status, valid while the bus clock enable is high
    typedef struct packed {
        logic instr_done;
        logic ibit;
        logic software_interrupt_instr;
        logic wait_op;
        logic stop_op;
        logic return_from_interrupt_instr;
        logic vec_ack;
    } elp_cpu_stat_t;

    typedef struct packed {
        logic       entry;
        logic       set_ibit;
        logic       clr_ibit;
        logic       push_pc_dec;
        logic       push_h;
        logic       break_state;
        logic [3:0] vec;
    } elp_cpu_ctl_t;
endpackage

// ---- rtl/elp_exc_ctrl.sv ----
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "elp_params.svh"
// Operation
// - on entry the core stacks registers and sets i; return restores them
// - latch pending interrupts, arbitrate at entry, give vector select constant
// - a latched interrupt holds until serviced, whatever arrives later
// - hardware interrupts are examined only at instruction completion
// - service only with i clear and source enabled, else continue
// - among several pending, highest priority served first
// - interrupt still pending at return is served before next instruction
// - interrupt entry never stacks the index high register
// - software interrupt ignores the i bit
// - software interrupt stacks pc, hardware interrupt stacks pc minus one
// - reset outranks every interrupt and is not arbitrated
// - break request forces a fetch from the software interrupt vector
// - with clear enable low, flags elsewhere stay set during break
// - with clear enable high, normal clearing works and sticks
// - two-step clears stay blocked in break, second step after break clears
// - wait or stop clears i and holds the core unclocked
// - wait stops core clocks, peripherals run, enabled interrupt wakes
// - wait wake stacking starts at the first bus edge that sees the enabled interrupt
// - reset or break ends wait; break in wait sets exit flag
// - watchdog runs through wait when its disable bit is zero
// - stop clears counter, gates both generator outputs; irq, reset, break exit
// - stacking after stop waits 4096 or 32 reference cycles
// - exit flag cleared by writing zero or by any reset
// - clear enable one allows, zero blocks flag clearing in break
module elp_exc_ctrl (
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic [`ELP_AW-1:0]     bus_addr_i,
    input  wire logic [`ELP_DW-1:0]     bus_wdata_i,
    input  wire logic                   bus_wr_i,
    input  wire logic                   bus_rd_i,
    output logic      [`ELP_DW-1:0]     bus_rdata_o,
    input  wire elp_pkg::elp_cpu_stat_t cpu_stat_i,
    output elp_pkg::elp_cpu_ctl_t       cpu_ctl_o,
    input  wire logic [`ELP_NIRQ-1:0]   irq_i,
    input  wire logic                   brk_req_i,
    input  wire logic                   reset_req_i,
    output logic                        bus_clk_en_o,
    output logic                        cpu_clk_en_o,
    output logic                        periph_clk_en_o,
    output logic                        xtal_clk_en_o,
    output logic                        gen_bus_clk_out_en_o,
    output logic      [`ELP_CNTW-1:0]   sim_cnt_o,
    output logic                        flag_clear_allow_o,
    output logic                        watchdog_run_o
);
    import elp_pkg::*;

    elp_state_t              state;
    elp_state_t              next_state;
    logic [`ELP_DIVW-1:0]    div;
    logic                    bus_en;
    logic [`ELP_CNTW-1:0]    cnt;
    logic                    latched;
    logic [`ELP_IDXW-1:0]    lidx;
    logic                    brk_active;
    logic                    exit_flag;
    logic                    break_flag_clear_enable;
    logic                    wdd;
    logic                    ssr;
    logic [`ELP_NIRQ-1:0]    ien;
    logic [`ELP_NIRQ-1:0]    pend;
    logic [`ELP_IDXW-1:0]    win_idx;
    logic                    wake_brk;
    logic                    rec_done;
    logic                    take_hw;
    logic                    take_swi;
    logic                    take_brk;
    elp_cpu_ctl_t            next_ctl;

    // lowest index wins
    function automatic logic [`ELP_IDXW-1:0] prio(input logic [`ELP_NIRQ-1:0] p);
        logic [`ELP_IDXW-1:0] r;
        r = '0;
        for (int i = `ELP_NIRQ-1; i >= 0; i--) begin
            if (p[i]) begin
                r = i[`ELP_IDXW-1:0];
            end
        end
        return r;
    endfunction

    function automatic logic [`ELP_VECW-1:0] irq_vec(input logic [`ELP_IDXW-1:0] idx);
        return `ELP_VEC_IRQ0 - {1'b0, idx};
    endfunction

    // bus rate enable, a quarter of the reference rate
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end
    assign bus_en = (div == `ELP_DIV_LAST);

    assign pend     = irq_i & ien;
    assign win_idx  = latched ? lidx : prio(pend);
    assign rec_done = (state == ST_SREC) &&
                      (cnt == (ssr ? `ELP_REC_SHORT : `ELP_REC_LONG));

    // swi and hardware decisions only at instruction completion; break is taken at any bus edge
    assign take_brk = brk_req_i;
    assign take_swi = cpu_stat_i.instr_done && cpu_stat_i.software_interrupt_instr;
    assign take_hw  = cpu_stat_i.instr_done && !cpu_stat_i.ibit &&
                      (latched || (|pend));

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (bus_en) begin
                    if (take_brk || take_swi || take_hw) begin
                        next_state = ST_ENTRY;
                    end else if (cpu_stat_i.instr_done && cpu_stat_i.stop_op) begin
                        next_state = ST_STOP;
                    end else if (cpu_stat_i.instr_done && cpu_stat_i.wait_op) begin
                        next_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (bus_en && (take_brk || (|pend))) begin
                    next_state = ST_ENTRY;
                end
            end
            ST_STOP: begin
                if (take_brk || (|pend)) begin
                    next_state = ST_SREC;
                end
            end
            ST_SREC: begin
                if (rec_done) begin
                    next_state = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (bus_en) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_RUN;
        end else if (reset_req_i) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // break seen while stopped is remembered until the core is back in run
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_brk <= 1'b0;
        end else if (reset_req_i || state == ST_RUN) begin
            wake_brk <= 1'b0;
        end else if (state == ST_STOP && take_brk) begin
            wake_brk <= 1'b1;
        end
    end

    // counter held clear in stop, free running otherwise
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else if (state == ST_STOP || (next_state == ST_STOP && !reset_req_i)) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            latched <= 1'b0;
            lidx    <= '0;
        end else if (reset_req_i) begin
            latched <= 1'b0;
        end else if (bus_en && (cpu_stat_i.vec_ack || cpu_stat_i.return_from_interrupt_instr)) begin
            latched <= 1'b0;
        end else if (bus_en && !latched && (|pend) && !cpu_stat_i.ibit &&
                     (cpu_stat_i.instr_done || state == ST_WAIT)) begin
            latched <= 1'b1;
            lidx    <= prio(pend);
        end
    end

    // entry command, built when the entry state is chosen
    always_comb begin
        next_ctl             = cpu_ctl_o;
        next_ctl.entry       = 1'b0;
        next_ctl.set_ibit    = 1'b0;
        next_ctl.clr_ibit    = 1'b0;
        next_ctl.push_h      = 1'b0;
        next_ctl.break_state = brk_active;
        if (next_state == ST_ENTRY && state != ST_ENTRY) begin
            next_ctl.entry       = 1'b1;
            next_ctl.set_ibit    = 1'b1;
            if (take_brk || (state == ST_SREC && wake_brk)) begin
                next_ctl.vec         = `ELP_VEC_SWI;
                next_ctl.push_pc_dec = 1'b0;
                next_ctl.break_state = 1'b1;
            end else if (state == ST_RUN && take_swi) begin
                next_ctl.vec         = `ELP_VEC_SWI;
                next_ctl.push_pc_dec = 1'b0;
            end else begin
                next_ctl.vec         = irq_vec(win_idx);
                next_ctl.push_pc_dec = 1'b1;
            end
        end else if (state == ST_ENTRY) begin
            next_ctl.entry    = 1'b1;
            next_ctl.set_ibit = 1'b1;
        end else if (next_state == ST_WAIT || next_state == ST_STOP) begin
            next_ctl.clr_ibit = (state == ST_RUN);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_ctl_o     <= '0;
            cpu_ctl_o.vec <= `ELP_VEC_RESET;
        end else if (reset_req_i) begin
            cpu_ctl_o     <= '0;
            cpu_ctl_o.vec <= `ELP_VEC_RESET;
        end else begin
            cpu_ctl_o <= next_ctl;
        end
    end

    // break state lasts until the return from the break routine
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            brk_active <= 1'b0;
        end else if (reset_req_i) begin
            brk_active <= 1'b0;
        end else if (next_ctl.entry && next_ctl.break_state && state != ST_ENTRY) begin
            brk_active <= 1'b1;
        end else if (bus_en && cpu_stat_i.return_from_interrupt_instr) begin
            brk_active <= 1'b0;
        end
    end

    // exit flag: set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            exit_flag <= 1'b0;
        end else if (reset_req_i) begin
            exit_flag <= 1'b0;
        end else if (take_brk && (state == ST_WAIT || state == ST_STOP)) begin
            exit_flag <= 1'b1;
        end else if (bus_wr_i && bus_addr_i == `ELP_ADDR_BSR &&
                     !bus_wdata_i[`ELP_BIT_BELP]) begin
            exit_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            break_flag_clear_enable <= 1'b0;
            wdd  <= 1'(`ELP_OPT_RST >> `ELP_BIT_WDD);
            ssr  <= 1'(`ELP_OPT_RST >> `ELP_BIT_SSR);
            ien  <= `ELP_IEN_RST;
        end else if (bus_wr_i) begin
            case (bus_addr_i)
                `ELP_ADDR_BFCR: begin
                    break_flag_clear_enable <= bus_wdata_i[`ELP_BIT_BREAK_FLAG_CLEAR_ENABLE];
                end
                `ELP_ADDR_OPT: begin
                    wdd <= bus_wdata_i[`ELP_BIT_WDD];
                    ssr <= bus_wdata_i[`ELP_BIT_SSR];
                end
                `ELP_ADDR_IEN: begin
                    ien <= bus_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= '0;
        end else if (bus_rd_i) begin
            case (bus_addr_i)
                `ELP_ADDR_BSR:  bus_rdata_o <= `ELP_DW'(exit_flag) << `ELP_BIT_BELP;
                `ELP_ADDR_BFCR: bus_rdata_o <= `ELP_DW'(break_flag_clear_enable) << `ELP_BIT_BREAK_FLAG_CLEAR_ENABLE;
                `ELP_ADDR_OPT:  bus_rdata_o <= (`ELP_DW'(ssr) << `ELP_BIT_SSR) |
                                               (`ELP_DW'(wdd) << `ELP_BIT_WDD);
                `ELP_ADDR_IEN:  bus_rdata_o <= ien;
                `ELP_ADDR_STAT: bus_rdata_o <= {state, latched, brk_active, lidx};
                default:        bus_rdata_o <= '0;
            endcase
        end else begin
            bus_rdata_o <= '0;
        end
    end

    // status modules outside hold clears off unless enabled in break;
    // they also gate the second step of a two-step clear with this
    assign flag_clear_allow_o = !brk_active || break_flag_clear_enable;

    assign bus_clk_en_o         = bus_en;
    assign cpu_clk_en_o         = bus_en && (state == ST_RUN || state == ST_ENTRY);
    assign periph_clk_en_o      = bus_en && (state == ST_RUN || state == ST_ENTRY ||
                                             state == ST_WAIT);
    assign xtal_clk_en_o        = (state != ST_STOP);
    assign gen_bus_clk_out_en_o = (state != ST_STOP) && (state != ST_SREC);
    assign watchdog_run_o       = !wdd && (state != ST_STOP) && (state != ST_SREC);
    assign sim_cnt_o            = cnt;

endmodule // elp_exc_ctrl

// ---- test/elp_exc_ctrl_sva.sv ----
`timescale 1ns/1ps
`include "elp_params.svh"
module elp_exc_ctrl_sva (
    input wire logic                  ref_clk_i,
    input wire logic                  rst_n_i,
    input wire logic                  reset_req_i,
    input wire elp_pkg::elp_cpu_ctl_t cpu_ctl_o,
    input wire logic                  bus_clk_en_o,
    input wire logic                  cpu_clk_en_o,
    input wire logic                  periph_clk_en_o,
    input wire logic                  xtal_clk_en_o,
    input wire logic                  gen_bus_clk_out_en_o,
    input wire logic [`ELP_CNTW-1:0]  sim_cnt_o,
    input wire logic                  watchdog_run_o
);
    import elp_pkg::*;
    logic [12:0] srec_n;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // length of the recovery seen at the pins, saturating
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            srec_n <= 13'h0000;
        end else if (xtal_clk_en_o && !gen_bus_clk_out_en_o) begin
            srec_n <= (srec_n == 13'h1FFF) ? srec_n : srec_n + 13'h0001;
        end else begin
            srec_n <= 13'h0000;
        end
    end
    a_no_h_push: assert property (!cpu_ctl_o.push_h)
        else $error("index high pushed");
    a_entry_sets_i: assert property (cpu_ctl_o.entry |-> cpu_ctl_o.set_ibit)
        else $error("entry without mask set");
    a_hw_pc_dec: assert property ($rose(cpu_ctl_o.entry) && cpu_ctl_o.vec <= 4'hD
        |-> cpu_ctl_o.push_pc_dec) else $error("hw entry without pc minus one");
    a_swi_pc: assert property ($rose(cpu_ctl_o.entry) && cpu_ctl_o.vec == 4'hE
        && !cpu_ctl_o.break_state |-> !cpu_ctl_o.push_pc_dec) else $error("swi pushed pc-1");
    a_reset_first: assert property (reset_req_i |=> cpu_ctl_o.vec == 4'hF)
        else $error("reset vector not given");
    a_stop_gates: assert property (!xtal_clk_en_o |-> !gen_bus_clk_out_en_o
        && sim_cnt_o == 12'h000) else $error("stop left clocks or counter running");
    a_stop_core: assert property (!gen_bus_clk_out_en_o |-> !cpu_clk_en_o
        && !periph_clk_en_o && !watchdog_run_o) else $error("clocks alive in stop");
    a_core_subset: assert property (cpu_clk_en_o |-> periph_clk_en_o && bus_clk_en_o)
        else $error("core clock outside peripheral clock");
    a_recovery_len: assert property ($rose(gen_bus_clk_out_en_o) |-> srec_n >= 13'd31)
        else $error("stop recovery too short");
    a_no_early_stack: assert property (!gen_bus_clk_out_en_o |-> !cpu_ctl_o.entry)
        else $error("stacking during stop recovery");
    c_swi: cover property ($rose(cpu_ctl_o.entry) && cpu_ctl_o.vec == 4'hE);
    c_stop: cover property ($fell(xtal_clk_en_o));
    c_brk: cover property ($rose(cpu_ctl_o.break_state));
endmodule // elp_exc_ctrl_sva

// ---- test/elp_core_model.sv ----
`timescale 1ns/1ps
module elp_core_model (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  bus_clk_en_i,
    input  wire elp_pkg::elp_cpu_ctl_t cpu_ctl_i,
    input  wire logic [2:0]            op_i,
    output elp_pkg::elp_cpu_stat_t     stat_o
);
    import elp_pkg::*;
    // op 1 swi, 2 wait, 3 stop, 4 return; fields move only on bus edges, except the i bit clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_o <= '0;
        end else begin
            if (bus_clk_en_i) begin
                stat_o.instr_done <= !cpu_ctl_i.entry;
                stat_o.vec_ack    <= cpu_ctl_i.entry;
                stat_o.software_interrupt_instr        <= (op_i == 3'h1);
                stat_o.wait_op    <= (op_i == 3'h2);
                stat_o.stop_op    <= (op_i == 3'h3);
                stat_o.return_from_interrupt_instr        <= (op_i == 3'h4);
                if (cpu_ctl_i.set_ibit)
                    stat_o.ibit <= 1'b1;
                else if (op_i == 3'h4)
                    stat_o.ibit <= 1'b0;
            end
            // one-cycle pulse, so caught on any edge
            if (cpu_ctl_i.clr_ibit)
                stat_o.ibit <= 1'b0;
        end
    end
endmodule // elp_core_model

// ---- test/test_elp_exc_ctrl.sv ----
`timescale 1ns/1ps
`include "elp_params.svh"
module test_elp_exc_ctrl;
    import elp_pkg::*;
    logic                 ref_clk_i = 1'b0, rst_n_i = 1'b0;
    logic [`ELP_AW-1:0]   bus_addr_i = '0;
    logic [`ELP_DW-1:0]   bus_wdata_i = '0, bus_rdata_o, d;
    logic                 bus_wr_i = 1'b0, bus_rd_i = 1'b0;
    elp_cpu_stat_t        cpu_stat_i;
    elp_cpu_ctl_t         cpu_ctl_o;
    logic [`ELP_NIRQ-1:0] irq_i = '0;
    logic                 brk_req_i = 1'b0, reset_req_i = 1'b0;
    logic [2:0]           op = 3'h0;
    logic                 bus_clk_en_o, cpu_clk_en_o, periph_clk_en_o, xtal_clk_en_o;
    logic                 gen_bus_clk_out_en_o, flag_clear_allow_o, watchdog_run_o;
    logic [`ELP_CNTW-1:0] sim_cnt_o;
    int                   n_mismatch = 0, checked = 0, n, nc, np;
    elp_exc_ctrl dut (.ref_clk_i, .rst_n_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i,
        .bus_rdata_o, .cpu_stat_i, .cpu_ctl_o, .irq_i, .brk_req_i, .reset_req_i,
        .bus_clk_en_o, .cpu_clk_en_o, .periph_clk_en_o, .xtal_clk_en_o,
        .gen_bus_clk_out_en_o, .sim_cnt_o, .flag_clear_allow_o, .watchdog_run_o);
    elp_core_model core (.ref_clk_i, .rst_n_i, .bus_clk_en_i(bus_clk_en_o),
        .cpu_ctl_i(cpu_ctl_o), .op_i(op), .stat_o(cpu_stat_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        bus_addr_i <= a;
        bus_wdata_i <= v;
        bus_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        bus_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        bus_rd_i <= 1'b0;
        #1 d = bus_rdata_o;
    endtask
    // held for four edges: exactly one bus edge sees it
    task automatic do_op(input logic [2:0] k);
        @(posedge ref_clk_i);
        op <= k;
        repeat (4) @(posedge ref_clk_i);
        op <= 3'h0;
        #1;
    endtask
    task automatic set_irq(input logic [7:0] v);
        @(posedge ref_clk_i);
        irq_i <= v;
    endtask
    task automatic wait_entry(input int lim);
        n = 0;
        while (cpu_ctl_o.entry !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_reset();
        chk(cpu_ctl_o.vec, `ELP_VEC_RESET);
        chk({xtal_clk_en_o, gen_bus_clk_out_en_o, flag_clear_allow_o}, 3'h7);
        chk(watchdog_run_o, 1'b1);
        rd(`ELP_ADDR_OPT);
        chk(d, `ELP_OPT_RST);
        rd(`ELP_ADDR_IEN);
        chk(d, `ELP_IEN_RST);
        rd(4'hF);
        chk(d, 8'h00);
        rd(`ELP_ADDR_STAT);
        chk(d, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_prio();
        set_irq(8'h24);
        wait_entry(60);
        chk(n, 60);
        wr(`ELP_ADDR_IEN, 8'hFF);
        wait_entry(20);
        chk({cpu_ctl_o.vec, cpu_ctl_o.push_pc_dec, cpu_ctl_o.push_h}, 6'h2E);
        set_irq(8'h25);
        tick(2);
        chk(cpu_ctl_o.vec, 4'hB);
        tick(12);
        set_irq(8'h20);
        wait_entry(40);
        chk(n, 40);
        do_op(3'h4);
        wait_entry(20);
        chk(cpu_ctl_o.vec, 4'h8);
        set_irq(8'h00);
        tick(12);
        do_op(3'h4);
        $display("test priority done");
    endtask
    task automatic t_swi_wait();
        tick(8);
        do_op(3'h1);
        wait_entry(20);
        chk({cpu_ctl_o.vec, cpu_ctl_o.push_pc_dec}, 5'h1C);
        wr(`ELP_ADDR_IEN, 8'h08);
        tick(12);
        chk(cpu_stat_i.ibit, 1'b1);
        do_op(3'h2);
        tick(8);
        chk(cpu_stat_i.ibit, 1'b0);
        nc = 0;
        np = 0;
        repeat (16) begin
            tick(1);
            nc += cpu_clk_en_o;
            np += periph_clk_en_o;
        end
        chk({nc[7:0], np[7:0], 7'h00, watchdog_run_o}, 24'h000401);
        set_irq(8'h08);
        wait_entry(12);
        chk({cpu_ctl_o.vec, 3'h0, n <= 5}, 8'hA1);
        set_irq(8'h00);
        tick(12);
        $display("test swi wait done");
    endtask
    task automatic t_brk();
        do_op(3'h2);
        tick(8);
        @(posedge ref_clk_i);
        brk_req_i <= 1'b1;
        wait_entry(12);
        @(posedge ref_clk_i);
        brk_req_i <= 1'b0;
        chk({cpu_ctl_o.vec, cpu_ctl_o.break_state}, 5'h1D);
        rd(`ELP_ADDR_BSR);
        chk(d[`ELP_BIT_BELP], 1'b1);
        chk(flag_clear_allow_o, 1'b0);
        wr(`ELP_ADDR_BFCR, 8'h80);
        tick(1);
        chk(flag_clear_allow_o, 1'b1);
        wr(`ELP_ADDR_BFCR, 8'h00);
        tick(1);
        chk(flag_clear_allow_o, 1'b0);
        wr(`ELP_ADDR_BSR, 8'h00);
        rd(`ELP_ADDR_BSR);
        chk(d[`ELP_BIT_BELP], 1'b0);
        tick(8);
        do_op(3'h4);
        tick(8);
        chk({cpu_ctl_o.break_state, flag_clear_allow_o}, 2'h1);
        @(posedge ref_clk_i);
        reset_req_i <= 1'b1;
        @(posedge ref_clk_i);
        reset_req_i <= 1'b0;
        #1 chk(cpu_ctl_o.vec, `ELP_VEC_RESET);
        $display("test break done");
    endtask
    task automatic t_stop(input logic [7:0] opt, input int lo, input int hi);
        wr(`ELP_ADDR_OPT, opt);
        wr(`ELP_ADDR_IEN, 8'h02);
        tick(1);
        chk(watchdog_run_o, !opt[0]);
        do_op(3'h3);
        tick(8);
        chk({xtal_clk_en_o, gen_bus_clk_out_en_o, sim_cnt_o}, 14'h0000);
        set_irq(8'h02);
        wait_entry(5000);
        chk({cpu_ctl_o.vec, 3'h0, n >= lo && n <= hi}, 8'hC1);
        set_irq(8'h00);
        tick(12);
        do_op(3'h4);
        $display("test stop done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    // whole run is about 4600 cycles
    initial begin
        #1000000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        tick(1);
        t_reset();
        t_prio();
        t_swi_wait();
        t_brk();
        t_stop(8'h81, 32, 45);
        t_stop(8'h00, 4096, 4110);
        give_verdict();
    end
endmodule // test_elp_exc_ctrl
bind elp_exc_ctrl elp_exc_ctrl_sva u_sva (.ref_clk_i, .rst_n_i, .reset_req_i, .cpu_ctl_o,
    .bus_clk_en_o, .cpu_clk_en_o, .periph_clk_en_o, .xtal_clk_en_o, .gen_bus_clk_out_en_o,
    .sim_cnt_o, .watchdog_run_o);
